// ### verilog/pie_pkg.sv
// constants, source table and state type of the interrupt expansion block
package pie_pkg;

  // ==========================================================
  // register byte offsets on the wishbone slave
  localparam logic [7:0] A_PEND = 8'h00;
  localparam logic [7:0] A_MASK = 8'h04;
  localparam logic [7:0] A_VEC5 = 8'h08;
  localparam logic [7:0] A_VEC6 = 8'h0c;
  localparam logic [7:0] A_SWI  = 8'h10;

  // ==========================================================
  // pending bit positions of each source
  localparam logic [3:0] BIT_SPI  = 4'h7;
  localparam logic [3:0] BIT_RX   = 4'h8;
  localparam logic [3:0] BIT_TX   = 4'h9;
  localparam logic [3:0] BIT_MBX  = 4'ha;
  localparam logic [3:0] BIT_BERR = 4'hb;
  localparam logic [3:0] BIT_ADC  = 4'hc;
  localparam logic [3:0] BIT_EXT1 = 4'hd;
  localparam logic [3:0] BIT_EXT2 = 4'he;

  // ==========================================================
  // peripheral vector codes
  localparam logic [15:0] CODE_SPI     = 16'h0005;
  localparam logic [15:0] CODE_RX      = 16'h0006;
  localparam logic [15:0] CODE_TX      = 16'h0007;
  localparam logic [15:0] CODE_MBX     = 16'h0040;
  localparam logic [15:0] CODE_BERR    = 16'h0041;
  localparam logic [15:0] CODE_ADC     = 16'h0004;
  localparam logic [15:0] CODE_EXT1    = 16'h0001;
  localparam logic [15:0] CODE_EXT2    = 16'h0011;
  localparam logic [15:0] CODE_PHANTOM = 16'h0000;

  // ==========================================================
  // source table, listed in overall priority order (first wins)
  localparam int NSRC = 8;
  localparam logic [3:0] SRC_BIT [NSRC] = '{BIT_SPI, BIT_RX, BIT_TX,
    BIT_MBX, BIT_BERR, BIT_ADC, BIT_EXT1, BIT_EXT2};
  localparam logic [15:0] SRC_CODE [NSRC] = '{CODE_SPI, CODE_RX, CODE_TX,
    CODE_MBX, CODE_BERR, CODE_ADC, CODE_EXT1, CODE_EXT2};

  // ==========================================================
  // core level grouping and core vector addresses
  localparam logic [15:0] LVL5_SET  = 16'h1f80;
  localparam logic [15:0] LVL6_SET  = 16'h6000;
  localparam logic [15:0] SRC_SET   = 16'h7f80;
  localparam logic [15:0] CORE_VEC5 = 16'h000a;
  localparam logic [15:0] CORE_VEC6 = 16'h000c;

  // ==========================================================
  // software-only core interrupt numbers and their vectors
  localparam logic [4:0] SWI_FIRST = 5'h14;
  localparam logic [4:0] SWI_LAST  = 5'h1f;
  localparam logic [7:0] SWI_BASE  = 8'h28;
  localparam logic [7:0] SWI_TOP   = 8'h3f;

  // ==========================================================
  // reset values
  localparam logic [15:0] PEND_RST = 16'h0000;
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [31:0] DAT_RST  = 32'h0000_0000;
  localparam logic [7:0]  SWA_RST  = 8'h00;

  // ==========================================================
  // whole state of the block
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
    logic [15:0] pend;
    logic [15:0] mask;
    logic        irq;
    logic        lv5;
    logic        lv6;
    logic        swt;
    logic [7:0]  swa;
  } pie_state_t;

endpackage

// ### verilog/pie_top.sv
// peripheral interrupt expansion: pending bits, vectors, wishbone slave
//
// Contract
// - serial port request sets bit 7, code 0005h
// - async receive sets bit 8, code 0006h
// - transmit sets bit 9, code 0007h, level five
// - mailbox request sets bit 10, code 0040h
// - bus error request sets bit 11, code 0041h
// - conversion done sets bit 12, code 0004h
// - external pins set bits 13/14, level six
// - nothing pending reads phantom code 0000h
// - core numbers 20-31 map to 28h-3Fh, software only
//
// The placing of the registers and the Wishbone slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module pie_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        serial_port_request_i,
  input  wire logic        async_receive_request_i,
  input  wire logic        async_transmit_request_i,
  input  wire logic        mailbox_request_i,
  input  wire logic        bus_error_request_i,
  input  wire logic        conversion_done_request_i,
  input  wire logic        ext_pin_one_request_i,
  input  wire logic        ext_pin_two_request_i,
  output logic             irq_o,
  output logic             core_level_five_o,
  output logic             core_level_six_o,
  output logic             sw_trig_o,
  output logic      [7:0]  sw_vec_addr_o
);

  // ==========================================================
  // state and request gathering
  pie_pkg::pie_state_t st;
  pie_pkg::pie_state_t next_st;
  logic [15:0]         req;
  logic                acc;

  // bus request taken this cycle
  assign acc = wb_cyc_i & wb_stb_i & ~st.ack;

  // map each request input onto its pending position
  always_comb begin
    req = 16'h0000;
    req[pie_pkg::BIT_SPI] = serial_port_request_i;
    req[pie_pkg::BIT_RX] = async_receive_request_i;
    req[pie_pkg::BIT_TX] = async_transmit_request_i;
    req[pie_pkg::BIT_MBX] = mailbox_request_i;
    req[pie_pkg::BIT_BERR] = bus_error_request_i;
    req[pie_pkg::BIT_ADC] = conversion_done_request_i;
    req[pie_pkg::BIT_EXT1] = ext_pin_one_request_i;
    req[pie_pkg::BIT_EXT2] = ext_pin_two_request_i;
  end

  // ==========================================================
  // vector selection per core level
  logic [15:0] live;
  logic [15:0] code5;
  logic [15:0] code6;
  logic [15:0] clr5;
  logic [15:0] clr6;

  // scan backwards so the first table entry wins
  always_comb begin
    live  = st.pend & st.mask;
    code5 = pie_pkg::CODE_PHANTOM;
    code6 = pie_pkg::CODE_PHANTOM;
    clr5  = 16'h0000;
    clr6  = 16'h0000;
    for (int i = pie_pkg::NSRC - 1; i >= 0; i--) begin
      if (live[pie_pkg::SRC_BIT[i]] &&
          pie_pkg::LVL5_SET[pie_pkg::SRC_BIT[i]]) begin
        code5 = pie_pkg::SRC_CODE[i];
        clr5  = 16'h0001 << pie_pkg::SRC_BIT[i];
      end
      if (live[pie_pkg::SRC_BIT[i]] &&
          pie_pkg::LVL6_SET[pie_pkg::SRC_BIT[i]]) begin
        code6 = pie_pkg::SRC_CODE[i];
        clr6  = 16'h0001 << pie_pkg::SRC_BIT[i];
      end
    end
  end

  // ==========================================================
  // software vector request decode
  logic [4:0] swi_num;
  logic [4:0] swi_off;
  logic       swi_ok;

  // only numbers 20 through 31 are accepted
  always_comb begin
    swi_num = wb_dat_i[4:0];
    swi_off = swi_num - pie_pkg::SWI_FIRST;
    swi_ok  = (swi_num >= pie_pkg::SWI_FIRST) &&
              (swi_num <= pie_pkg::SWI_LAST);
  end

  // ==========================================================
  // next state: bus slave, pending bits, outputs
  logic [15:0] wmask;
  logic [15:0] clr;

  always_comb begin
    next_st     = st;
    wmask       = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    clr         = 16'h0000;
    next_st.ack = acc;
    next_st.swt = 1'h0;
    if (acc) begin
      next_st.dat = 32'h0000_0000;
      if (wb_adr_i == pie_pkg::A_PEND) begin
        next_st.dat[15:0] = st.pend;
        if (wb_we_i) begin
          clr = wb_dat_i[15:0] & wmask; // write one to clear
        end
      end else if (wb_adr_i == pie_pkg::A_MASK) begin
        next_st.dat[15:0] = st.mask;
        if (wb_we_i) begin
          next_st.mask = ((wb_dat_i[15:0] & wmask) |
                          (st.mask & ~wmask)) & pie_pkg::SRC_SET;
        end
      end else if (wb_adr_i == pie_pkg::A_VEC5) begin
        // reading the vector acknowledges that source
        next_st.dat = {pie_pkg::CORE_VEC5, code5};
        if (!wb_we_i) begin
          clr = clr5;
        end
      end else if (wb_adr_i == pie_pkg::A_VEC6) begin
        next_st.dat = {pie_pkg::CORE_VEC6, code6};
        if (!wb_we_i) begin
          clr = clr6;
        end
      end else if (wb_adr_i == pie_pkg::A_SWI) begin
        next_st.dat[7:0] = st.swa;
        // software vector address, two words each
        if (wb_we_i && wb_sel_i[0] && swi_ok) begin
          next_st.swt = 1'h1;
          next_st.swa = pie_pkg::SWI_BASE + {2'h0, swi_off, 1'h0};
        end
      end
    end
    // set wins over clear in the same cycle
    next_st.pend = ((st.pend & ~clr) | req) & pie_pkg::SRC_SET;
    // transmit and friends drive level five
    next_st.lv5 = |(next_st.pend & next_st.mask & pie_pkg::LVL5_SET);
    next_st.lv6 = |(next_st.pend & next_st.mask & pie_pkg::LVL6_SET);
    next_st.irq = |(next_st.pend & next_st.mask);
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st.ack  <= 1'h0;
      st.dat  <= pie_pkg::DAT_RST;
      st.pend <= pie_pkg::PEND_RST;
      st.mask <= pie_pkg::MASK_RST;
      st.irq  <= 1'h0;
      st.lv5  <= 1'h0;
      st.lv6  <= 1'h0;
      st.swt  <= 1'h0;
      st.swa  <= pie_pkg::SWA_RST;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign wb_ack_o          = st.ack;
  assign wb_dat_o          = st.dat;
  assign irq_o             = st.irq;
  assign core_level_five_o = st.lv5;
  assign core_level_six_o  = st.lv6;
  assign sw_trig_o         = st.swt;
  assign sw_vec_addr_o     = st.swa;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic rd5;
  logic rd6;
  assign rd5 = acc && !wb_we_i && wb_adr_i == pie_pkg::A_VEC5;
  assign rd6 = acc && !wb_we_i && wb_adr_i == pie_pkg::A_VEC6;

  a_spi_pend: assert property (
    serial_port_request_i |=> st.pend[pie_pkg::BIT_SPI])
    else $error("serial port request not pending");

  a_rx_pend: assert property (
    async_receive_request_i |=> st.pend[pie_pkg::BIT_RX])
    else $error("receive request not pending");

  a_tx_level: assert property (
    async_transmit_request_i && st.mask[pie_pkg::BIT_TX]
    && !(wb_we_i && acc) |=> core_level_five_o)
    else $error("transmit request missed level five");

  a_mbx_pend: assert property (
    mailbox_request_i |=> st.pend[pie_pkg::BIT_MBX])
    else $error("mailbox request not pending");

  // error request alone reads its code
  a_berr_code: assert property (
    rd5 && (st.pend & st.mask) == (16'h0001 << pie_pkg::BIT_BERR)
    |=> wb_dat_o[15:0] == pie_pkg::CODE_BERR)
    else $error("bus error vector code wrong");

  a_adc_pend: assert property (
    conversion_done_request_i |=> st.pend[pie_pkg::BIT_ADC])
    else $error("conversion request not pending");

  // pin two reads its code on level six
  a_ext2_code: assert property (
    rd6 && (st.pend & st.mask) == (16'h0001 << pie_pkg::BIT_EXT2)
    |=> wb_dat_o == {pie_pkg::CORE_VEC6, pie_pkg::CODE_EXT2})
    else $error("pin two vector code wrong");

  a_phantom_code: assert property (
    rd5 && !(|(st.pend & st.mask & pie_pkg::LVL5_SET))
    |=> wb_dat_o[15:0] == pie_pkg::CODE_PHANTOM)
    else $error("phantom code not returned");

  a_swi_range: assert property (
    sw_trig_o |-> sw_vec_addr_o >= pie_pkg::SWI_BASE &&
    sw_vec_addr_o <= pie_pkg::SWI_TOP && !sw_vec_addr_o[0])
    else $error("software vector out of range");

  a_prio_first: assert property (
    rd5 && live[pie_pkg::BIT_SPI]
    |=> wb_dat_o[15:0] == pie_pkg::CODE_SPI &&
    (!st.pend[pie_pkg::BIT_SPI] || $past(serial_port_request_i)))
    else $error("priority order broken");

  a_vec_clear: assert property (
    rd6 && live == (16'h0001 << pie_pkg::BIT_EXT1)
    && !ext_pin_one_request_i |=> !st.pend[pie_pkg::BIT_EXT1])
    else $error("served pin request still pending");

  a_tx_pend: assert property (
    async_transmit_request_i |=> st.pend[pie_pkg::BIT_TX])
    else $error("transmit request not pending");

  a_berr_pend: assert property (
    bus_error_request_i |=> st.pend[pie_pkg::BIT_BERR])
    else $error("bus error request not pending");

  a_ext1_pend: assert property (
    ext_pin_one_request_i |=> st.pend[pie_pkg::BIT_EXT1])
    else $error("pin one request not pending");

  a_ext2_pend: assert property (
    ext_pin_two_request_i |=> st.pend[pie_pkg::BIT_EXT2])
    else $error("pin two request not pending");

  // receive request alone reads its code
  a_rx_code: assert property (
    rd5 && live == (16'h0001 << pie_pkg::BIT_RX)
    |=> wb_dat_o[15:0] == pie_pkg::CODE_RX)
    else $error("receive vector code wrong");

  // transmit request alone reads its code
  a_tx_code: assert property (
    rd5 && live == (16'h0001 << pie_pkg::BIT_TX)
    |=> wb_dat_o == {pie_pkg::CORE_VEC5, pie_pkg::CODE_TX})
    else $error("transmit vector code wrong");

  // mailbox request alone reads its code
  a_mbx_code: assert property (
    rd5 && live == (16'h0001 << pie_pkg::BIT_MBX)
    |=> wb_dat_o[15:0] == pie_pkg::CODE_MBX)
    else $error("mailbox vector code wrong");

  // conversion request alone reads its code
  a_adc_code: assert property (
    rd5 && live == (16'h0001 << pie_pkg::BIT_ADC)
    |=> wb_dat_o[15:0] == pie_pkg::CODE_ADC)
    else $error("conversion vector code wrong");

  // pin one reads its code on level six
  a_ext1_code: assert property (
    rd6 && live == (16'h0001 << pie_pkg::BIT_EXT1)
    |=> wb_dat_o == {pie_pkg::CORE_VEC6, pie_pkg::CODE_EXT1})
    else $error("pin one vector code wrong");

  a_ext_level: assert property (
    ext_pin_one_request_i && st.mask[pie_pkg::BIT_EXT1]
    && !(wb_we_i && acc) |=> core_level_six_o)
    else $error("pin request missed level six");

  a_swi_pulse: assert property (
    sw_trig_o |=> !sw_trig_o)
    else $error("software trigger held too long");

  a_swi_refuse: assert property (
    acc && wb_we_i && wb_adr_i == pie_pkg::A_SWI
    && wb_dat_i[4:0] < pie_pkg::SWI_FIRST |=> !sw_trig_o)
    else $error("software number below range accepted");

  // bus acknowledge lasts one cycle
  a_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held too long");

  // main scenarios
  c_vec5_read: cover property (rd5 ##1 wb_dat_o[15:0] != 16'h0000);
  c_phantom: cover property (rd6 ##1 wb_dat_o[15:0] == 16'h0000);
  c_swi_trig: cover property (sw_trig_o);
  c_level_six: cover property ($rose(core_level_six_o));
  c_pend_clear: cover property (acc && wb_we_i && wb_adr_i == pie_pkg::A_PEND);

endmodule

`default_nettype wire

// ### verification/pie_core_model.sv
// core model: wishbone master servicing the grouped levels
`timescale 1ns/10ps
`default_nettype none
module pie_core_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  input  wire logic        lv5_i,
  input  wire logic        lv6_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic      [7:0]  adr_o,
  output logic      [3:0]  sel_o,
  output logic      [31:0] dat_o
);
  // ==========================================================
  // bus idle at time zero
  initial begin
    cyc_o = 1'h0;
    stb_o = 1'h0;
    we_o  = 1'h0;
    adr_o = 8'h00;
    sel_o = 4'hf;
    dat_o = 32'h0;
  end

  // one classic cycle, held until ack is seen
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'h1;
    stb_o <= 1'h1;
    we_o  <= w;
    adr_o <= a;
    sel_o <= s;
    dat_o <= d;
    do @(posedge clk_i); while (ack_i !== 1'h1);
    q = dat_i;
    cyc_o <= 1'h0;
    stb_o <= 1'h0;
    we_o  <= 1'h0;
  endtask

  // level five served before six; let levels settle first
  task automatic svc(output logic [31:0] q);
    repeat (2) @(posedge clk_i);
    xfer(1'h0, (lv5_i === 1'h1) ? 8'h08 : 8'h0c, 32'h0, 4'hf, q);
  endtask
endmodule
`default_nettype wire

// ### verification/peripheral_interrupt_expansion_tb_top.sv
// self-checking bench of the interrupt expansion block
`timescale 1ns/10ps
`default_nettype none
module peripheral_interrupt_expansion_tb_top;
  logic        clk_i;
  logic        rst_i;
  logic [7:0]  req;
  logic        cyc, stb, we, ack, irq, lv5, lv6, trig;
  logic [7:0]  adr, swa;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  int          n_mismatch = 0;
  int          checks = 0;
  int          n_trig = 0;
  int          cycles = 0;
  // expected codes, index is pending bit minus 7
  logic [15:0] code [8] = '{16'h0005, 16'h0006, 16'h0007, 16'h0040,
                            16'h0041, 16'h0004, 16'h0001, 16'h0011};

  pie_top u_pie_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .serial_port_request_i(req[0]), .async_receive_request_i(req[1]),
    .async_transmit_request_i(req[2]), .mailbox_request_i(req[3]),
    .bus_error_request_i(req[4]), .conversion_done_request_i(req[5]),
    .ext_pin_one_request_i(req[6]), .ext_pin_two_request_i(req[7]),
    .irq_o(irq), .core_level_five_o(lv5), .core_level_six_o(lv6),
    .sw_trig_o(trig), .sw_vec_addr_o(swa));

  pie_core_model u_pie_core_model (.clk_i(clk_i), .ack_i(ack),
    .dat_i(rdat), .lv5_i(lv5), .lv6_i(lv6), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

  // ==========================================================
  // clock, pulse count and cycle ceiling
  initial begin
    clk_i = 1'h0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (trig === 1'h1) n_trig <= n_trig + 1;
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      close_out();
    end
  end

  // ==========================================================
  // shared helpers
  task automatic close_out();
    if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_pie_core_model.xfer(1'h1, a, d, 4'hf, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, string nm);
    logic [31:0] q;
    u_pie_core_model.xfer(1'h0, a, 32'h0, 4'hf, q);
    chk(nm, e, q);
  endtask
  task automatic pulse(input logic [7:0] m);
    @(posedge clk_i);
    req <= m;
    @(posedge clk_i);
    req <= 8'h00;
    repeat (2) @(posedge clk_i);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    chk("irq", 32'h0, {31'h0, irq});
    rd(8'h00, 32'h0, "pend");
    rd(8'h04, 32'h0, "mask");
    rd(8'h08, 32'h000a_0000, "phantom");
  endtask
  task automatic t_each();
    logic l5;
    wr(8'h04, 32'hffff_ffff);
    rd(8'h04, 32'h0000_7f80, "mask");
    for (int i = 0; i < 8; i++) begin
      l5 = (i < 6);
      pulse(8'h01 << i);
      chk("irq", 32'h1, {31'h0, irq});
      chk("lv5", {31'h0, l5}, {31'h0, lv5});
      chk("lv6", {31'h0, !l5}, {31'h0, lv6});
      rd(8'h00, 32'h1 << (i + 7), "pend");
      rd(l5 ? 8'h08 : 8'h0c, {l5 ? 16'h000a : 16'h000c, code[i]},
         "vector");
      rd(8'h00, 32'h0, "pend");
    end
  endtask
  task automatic t_prio();
    logic [31:0] q;
    pulse(8'hff);
    for (int k = 0; k < 9; k++) begin
      u_pie_core_model.svc(q);
      chk("order", (k == 8) ? 32'h000c_0000 :
          {(k < 6) ? 16'h000a : 16'h000c, code[k]}, q);
    end
  endtask
  task automatic t_mask();
    wr(8'h04, 32'h0);
    pulse(8'h01);
    chk("irq", 32'h0, {31'h0, irq});
    rd(8'h08, 32'h000a_0000, "masked");
    rd(8'h00, 32'h0000_0080, "pend");
    wr(8'h04, 32'h0000_0080);
    repeat (2) @(posedge clk_i);
    chk("irq", 32'h1, {31'h0, irq});
    wr(8'h00, 32'h0000_0080);
    repeat (2) @(posedge clk_i);
    chk("irq", 32'h0, {31'h0, irq});
    rd(8'h00, 32'h0, "pend");
  endtask
  task automatic t_swi();
    for (int n = 20; n < 32; n++) begin
      wr(8'h10, n);
      repeat (2) @(posedge clk_i);
      chk("trig", n - 19, n_trig);
      chk("swa", 32'h28 + 2 * (n - 20), {24'h0, swa});
    end
    wr(8'h10, 32'h13);
    repeat (2) @(posedge clk_i);
    chk("trig", 12, n_trig);
    rd(8'h10, 32'h0000_003e, "swa");
    wr(8'h14, 32'hffff_ffff);
    rd(8'h14, 32'h0, "unmapped");
    rd(8'h04, 32'h0000_0080, "mask");
  endtask
  task automatic t_lanes();
    logic [31:0] q;
    u_pie_core_model.xfer(1'h1, 8'h10, 32'h14, 4'he, q);
    repeat (2) @(posedge clk_i);
    chk("trig", 12, n_trig);
    rd(8'h10, 32'h0000_003e, "swa");
    u_pie_core_model.xfer(1'h1, 8'h04, 32'hffff_ffff, 4'h1, q);
    rd(8'h04, 32'h0000_0080, "mask lane");
    u_pie_core_model.xfer(1'h1, 8'h04, 32'hffff_ffff, 4'h2, q);
    rd(8'h04, 32'h0000_7f80, "mask lane");
  endtask
  task automatic t_rerst();
    pulse(8'h40);
    chk("lv6", 32'h1, {31'h0, lv6});
    @(posedge clk_i);
    rst_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    chk("lv6", 32'h0, {31'h0, lv6});
    t_reset();
    rd(8'h10, 32'h0, "swa");
  endtask

  // main sequence
  initial begin
    req   = 8'h00;
    rst_i = 1'h1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    t_reset();
    t_each();
    t_prio();
    t_mask();
    t_swi();
    t_lanes();
    t_rerst();
    close_out();
  end
endmodule
`default_nettype wire
